/* hw/pnsp_pkg.sv */
// Constants and types of the pipelined no-wait burst memory port
// How it works
// RULE1 - Clock gate high freezes command state, burst counter and pipeline
// RULE2 - Any inactive select means deselect
// RULE3 - Continued deselect only after deselect
// RULE4 - Selected load with write high reads
// RULE5 - Advance continues read at next address
// RULE6 - Output enable high gives dummy read
// RULE7 - Selected load, write low starts write
// RULE8 - Advance continues write at next address
// RULE9 - All lanes disabled writes nothing
// RULE10 - Write select picks read or write
// RULE11 - Each lane has own write enable
// RULE12 - Four lanes in 36-bit organization
// RULE13 - Eight lanes in 72-bit organization
// RULE14 - Controller wires seed bits to address LSBs
// RULE15 - Controller drops output enable before writing; the bench's initial fill and its sleep phase write with OUTPUT_ENABLE_N low
// RULE16 - Pins driven only sleep low, enable low
// RULE17 - Sleep forces all pins undriven
// RULE18 - Deselected keeps pins undriven
// RULE19 - Mode high gives interleaved order
// RULE20 - Mode low gives linear order
// RULE21 - Counter wraps in four-beat group
// RULE22 - Data two enabled edges after address
package pnsp_pkg;
  // ****************************************
  // Geometry and timing
  // ****************************************
  localparam int PNSP_ADDR_W    = 18;
  localparam int PNSP_LANES     = 8;
  localparam int PNSP_LANE_W    = 9;
  localparam int PNSP_PIPE      = 2;
  localparam int PNSP_BEAT_W    = 2;
  localparam int PNSP_SYNC_LEN  = 3;
  localparam logic [1:0] PNSP_BEAT_RST = 2'h0;

  typedef enum logic [1:0] {
    PNSP_IDLE,
    PNSP_READ,
    PNSP_WRITE
  } pnsp_state_e;
endpackage

/* hw/pnsp_port.sv */
// Synchronous burst memory port with pipelined no-wait data path
`timescale 1ns/1ps
module pnsp_port
  import pnsp_pkg::*;
#(
  parameter int ADDR_W = PNSP_ADDR_W,
  parameter int LANES  = PNSP_LANES,
  parameter int LANE_W = PNSP_LANE_W
) (
  // Clock and reset
  input  wire logic                CORE_CLK,
  input  wire logic                RST,
  // Synchronous controls
  input  wire logic                CLOCK_GATE_N_HOLD,
  input  wire logic                SELECT_N,
  input  wire logic                SECONDARY_SELECTS,
  input  wire logic                SECONDARY_SELECTS_N,
  input  wire logic                ADVANCE_OR_LOAD,
  input  wire logic                WRITE_SELECT_N,
  input  wire logic [LANES-1:0]    BYTE_LANE_WRITE_N,
  input  wire logic [ADDR_W-1:0]   ADDRESS,
  // Mode and asynchronous pins
  input  wire logic                BURST_ORDER,
  input  wire logic                OUTPUT_ENABLE_N,
  input  wire logic                SLEEP_REQUEST,
  // Data lanes, parity bit is top bit of each lane
  input  wire logic [LANES*LANE_W-1:0] DATA_LANES_IN,
  output logic      [LANES*LANE_W-1:0] DATA_LANES_OUT,
  output logic      [LANES*LANE_W-1:0] DATA_LANES_OE_N,
  // Status
  output logic                     SLEEPING
);
  localparam int DW    = LANES * LANE_W;
  localparam int DEPTH = 1 << ADDR_W;

  // ****************************************
  // Asynchronous pin capture
  // ****************************************
  logic [2:0] asy_pin;
  logic [2:0] asy_lvl;
  logic       oe_n_s;
  logic       sleep_s;
  logic       order_s;

  assign asy_pin = {BURST_ORDER, SLEEP_REQUEST, OUTPUT_ENABLE_N};

  pnsp_sync #(.W(3)) u_sync (
    .clk   (CORE_CLK),
    .rst   (RST),
    .pin   (asy_pin),
    .level (asy_lvl)
  );

  assign oe_n_s  = asy_lvl[0];
  assign sleep_s = asy_lvl[1];
  assign order_s = asy_lvl[2];

  // ****************************************
  // Command decode
  // ****************************************
  pnsp_state_e           state_r;
  pnsp_state_e           state_nxt;
  logic [ADDR_W-1:0]     base_r;
  logic [PNSP_BEAT_W-1:0] beat_r;
  logic [PNSP_BEAT_W-1:0] beat_nxt;
  logic [ADDR_W-1:0]     base_nxt;
  logic                  run;
  logic                  selected;
  logic                  load;
  logic                  advance_or_load;
  logic                  cont_rd;
  logic                  cont_wr;
  logic [PNSP_BEAT_W-1:0] seed;
  logic                  do_rd;
  logic                  do_wr;

  assign run      = ~CLOCK_GATE_N_HOLD; // RULE1
  assign selected = ~SELECT_N & SECONDARY_SELECTS
                  & ~SECONDARY_SELECTS_N; // RULE2
  assign load     = run & ~ADVANCE_OR_LOAD;
  assign advance_or_load      = run & ADVANCE_OR_LOAD;
  assign cont_rd  = advance_or_load & (state_r == PNSP_READ); // RULE5
  assign cont_wr  = advance_or_load & (state_r == PNSP_WRITE); // RULE8

  // Burst seed held from the load cycle
  assign seed     = base_r[PNSP_BEAT_W-1:0];

  always_comb begin
    state_nxt = state_r;
    base_nxt  = base_r;
    beat_nxt  = beat_r;
    if (load) begin
      base_nxt = ADDRESS;
      beat_nxt = PNSP_BEAT_RST;
      if (!selected) begin
        state_nxt = PNSP_IDLE;
      end else if (WRITE_SELECT_N) begin
        state_nxt = PNSP_READ; // RULE4 RULE10
      end else begin
        state_nxt = PNSP_WRITE; // RULE7 RULE10
      end
    end else if (cont_rd || cont_wr) begin
      beat_nxt = PNSP_BEAT_W'(beat_r + 2'h1); // RULE21
    end
    // Idle with advance high stays idle
  end

  // Operation of this cycle, against the address it uses
  logic [ADDR_W-1:0] op_addr;
  logic [PNSP_BEAT_W-1:0] adv_low;
  logic [PNSP_BEAT_W-1:0] adv_beat;

  assign adv_beat = PNSP_BEAT_W'(beat_r + 2'h1);
  assign adv_low  = order_s ? (seed ^ adv_beat)
                            : PNSP_BEAT_W'(seed + adv_beat); // RULE19 RULE20
  assign op_addr  = load ? ADDRESS
                         : {base_r[ADDR_W-1:PNSP_BEAT_W], adv_low}; // RULE21
  assign do_rd    = (load & selected & WRITE_SELECT_N) | cont_rd;
  assign do_wr    = (load & selected & ~WRITE_SELECT_N) | cont_wr;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      state_r <= PNSP_IDLE;
      base_r  <= '0;
      beat_r  <= PNSP_BEAT_RST;
    end else begin
      state_r <= state_nxt; // RULE3
      base_r  <= base_nxt;
      beat_r  <= beat_nxt;
    end
  end

  // ****************************************
  // Two-stage pipeline
  // ****************************************
  logic [PNSP_PIPE-1:0]  prd_r;
  logic [PNSP_PIPE-1:0]  pwr_r;
  logic [ADDR_W-1:0]     pad_r [PNSP_PIPE];
  logic [LANES-1:0]      pbw_r [PNSP_PIPE];
  logic [DW-1:0]         mem   [DEPTH];
  logic [DW-1:0]         rdata_r;
  logic [DW-1:0]         rdata_nxt;
  logic                  drive_r;
  logic                  drive_nxt;
  logic [DW-1:0]         out_r;
  logic [DW-1:0]         oe_n_r;
  logic [DW-1:0]         oe_n_nxt;
  logic                  rd_hit;

  assign rd_hit    = run & prd_r[PNSP_PIPE-1];
  assign rdata_nxt = rd_hit ? mem[pad_r[PNSP_PIPE-1]] : rdata_r;
  assign drive_nxt = run ? prd_r[PNSP_PIPE-1] : drive_r; // RULE22
  assign oe_n_nxt  = {DW{~(drive_nxt & ~oe_n_s
                           & ~sleep_s)}}; // RULE6 RULE16 RULE17 RULE18

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      prd_r    <= '0;
      pwr_r    <= '0;
      pad_r[0] <= '0;
      pad_r[1] <= '0;
      pbw_r[0] <= '1;
      pbw_r[1] <= '1;
      rdata_r  <= '0;
      drive_r  <= 1'b0;
    end else if (run) begin // RULE1
      prd_r    <= {prd_r[0], do_rd};
      pwr_r    <= {pwr_r[0], do_wr};
      pad_r[0] <= op_addr;
      pad_r[1] <= pad_r[0];
      pbw_r[0] <= BYTE_LANE_WRITE_N;
      pbw_r[1] <= pbw_r[0];
      rdata_r  <= rdata_nxt;
      drive_r  <= drive_nxt;
    end
  end

  // Per-lane merge, one writer for the whole array
  logic [LANES-1:0]      lane_we;
  logic [DW-1:0]         wr_word;

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      assign lane_we[g] = run & pwr_r[PNSP_PIPE-1]
                        & ~pbw_r[PNSP_PIPE-1][g]; // RULE11 RULE12 RULE13
      assign wr_word[g*LANE_W +: LANE_W] = lane_we[g]
        ? DATA_LANES_IN[g*LANE_W +: LANE_W]
        : mem[pad_r[PNSP_PIPE-1]][g*LANE_W +: LANE_W];
    end
  endgenerate

  always_ff @(posedge CORE_CLK) begin
    if (|lane_we) begin // RULE9
      mem[pad_r[PNSP_PIPE-1]] <= wr_word; // RULE22
    end
  end

  // ****************************************
  // Output pins
  // ****************************************
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      out_r    <= '0;
      oe_n_r   <= '1;
      SLEEPING <= 1'b0;
    end else begin
      out_r    <= rdata_nxt;
      oe_n_r   <= oe_n_nxt;
      SLEEPING <= sleep_s; // RULE17
    end
  end

  assign DATA_LANES_OUT  = out_r;
  assign DATA_LANES_OE_N = oe_n_r;

  // ****************************************
  // Checks
  // ****************************************
  property p_hold;
    @(posedge CORE_CLK) disable iff (RST)
      CLOCK_GATE_N_HOLD |=> (state_r == $past(state_r))
                          && (beat_r == $past(beat_r))
                          && (pad_r[0] == $past(pad_r[0]));
  endproperty
  a_hold: assert property (p_hold) // RULE1
    else $error("gated edge moved state");

  property p_desel;
    @(posedge CORE_CLK) disable iff (RST)
      (load && !selected) |=> state_r == PNSP_IDLE;
  endproperty
  a_desel: assert property (p_desel) // RULE2
    else $error("deselect missed");

  property p_cont_desel;
    @(posedge CORE_CLK) disable iff (RST)
      (state_r == PNSP_IDLE && advance_or_load) |=> state_r == PNSP_IDLE;
  endproperty
  a_cont_desel: assert property (p_cont_desel) // RULE3
    else $error("left idle");

  property p_rd_start;
    @(posedge CORE_CLK) disable iff (RST)
      (load && selected && WRITE_SELECT_N) |=> state_r == PNSP_READ;
  endproperty
  a_rd_start: assert property (p_rd_start) // RULE4
    else $error("read not begun");

  property p_wr_start;
    @(posedge CORE_CLK) disable iff (RST)
      (load && selected && !WRITE_SELECT_N) |=> state_r == PNSP_WRITE;
  endproperty
  a_wr_start: assert property (p_wr_start) // RULE7
    else $error("write not begun");

  property p_advance;
    @(posedge CORE_CLK) disable iff (RST)
      (cont_rd || cont_wr) |=>
        beat_r == PNSP_BEAT_W'($past(beat_r) + 2'h1);
  endproperty
  a_advance: assert property (p_advance) // RULE5 RULE8
    else $error("beat not advanced");

  // Upper address bits never move inside a burst
  property p_upper_fixed;
    @(posedge CORE_CLK) disable iff (RST)
      (cont_rd || cont_wr) |=> pad_r[0][ADDR_W-1:PNSP_BEAT_W]
                               == $past(pad_r[0][ADDR_W-1:PNSP_BEAT_W]);
  endproperty
  a_upper_fixed: assert property (p_upper_fixed) // RULE21
    else $error("burst left its group");

  property p_linear;
    @(posedge CORE_CLK) disable iff (RST)
      (cont_rd || cont_wr) && !order_s |=> pad_r[0][PNSP_BEAT_W-1:0]
        == PNSP_BEAT_W'($past(pad_r[0][PNSP_BEAT_W-1:0]) + 2'h1);
  endproperty
  a_linear: assert property (p_linear) // RULE20
    else $error("linear step wrong");

  property p_interleave;
    @(posedge CORE_CLK) disable iff (RST)
      (cont_rd || cont_wr) && order_s |=>
        (pad_r[0][PNSP_BEAT_W-1:0] ^ seed) == beat_r;
  endproperty
  a_interleave: assert property (p_interleave) // RULE19
    else $error("interleaved step wrong");

  property p_pipe;
    @(posedge CORE_CLK) disable iff (RST)
      (do_rd && run) ##1 run[*1] ##1 run |=> drive_r;
  endproperty
  a_pipe: assert property (p_pipe) // RULE22
    else $error("read data late");

  property p_sleep_hiz;
    @(posedge CORE_CLK) disable iff (RST)
      sleep_s |=> &DATA_LANES_OE_N;
  endproperty
  a_sleep_hiz: assert property (p_sleep_hiz) // RULE17
    else $error("driven in sleep");

  property p_oe_hiz;
    @(posedge CORE_CLK) disable iff (RST)
      oe_n_s |=> &DATA_LANES_OE_N;
  endproperty
  a_oe_hiz: assert property (p_oe_hiz) // RULE6
    else $error("dummy read drove");

  property p_sleep_flag;
    @(posedge CORE_CLK) disable iff (RST)
      1'b1 |=> SLEEPING == $past(sleep_s);
  endproperty
  a_sleep_flag: assert property (p_sleep_flag) // RULE17
    else $error("sleep status lags");
endmodule // pnsp_port

/* hw/pnsp_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pnsp_sync
  import pnsp_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Pin side and filtered value
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] level_nxt;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      assign level_nxt[g] = (s2_r[g] == s3_r[g]) ? s2_r[g] : level[g];
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      level <= '0;
    end else begin
      s1_r  <= pin;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      level <= level_nxt;
    end
  end
endmodule // pnsp_sync

/* verif/pnsp_ctrl_model.sv */
// Controller model that supplies write data behind the port
`timescale 1ns/1ps
module pnsp_ctrl_model (
  // Clock and command pins seen by the port
  input  wire logic        clk,
  input  wire logic        gate,
  input  wire logic        sel_n,
  input  wire logic        sel2,
  input  wire logic        sel2_n,
  input  wire logic        advance_or_load,
  input  wire logic        wr_n,
  // Write data towards the port
  output logic      [71:0] din
);
  // ****************************************
  // Write data two enabled edges late
  // ****************************************
  logic        wr_r   = 1'b0;
  logic [1:0]  pend_r = 2'h0;
  logic [95:0] tmp;
  int          seed   = 32'h078cce29;
  initial din = 72'h0;
  always @(posedge clk) begin
    if (!gate) begin
      if (!advance_or_load) wr_r = !sel_n && sel2 && !sel2_n && !wr_n;
      pend_r = {pend_r[0], wr_r};
      tmp = {$random(seed), $random(seed), $random(seed)};
      // Released bus flips every enabled cycle
      din <= pend_r[1] ? tmp[71:0] : ~din;
    end
  end
endmodule // pnsp_ctrl_model

/* verif/pnsp_port_tb_top.sv */
// Self-checking bench of the burst memory port
`timescale 1ns/1ps
module pnsp_port_tb_top;
  import pnsp_pkg::*;
  // ****************************************
  // Stimulus and reference state
  // ****************************************
  logic        clk = 0, rst = 1, gate = 0, sn = 1, s2 = 0, s2n = 1;
  logic        advance_or_load = 0, wen = 1, ord = 0, oen = 0, slp = 0;
  logic [7:0]  bw = 8'hff;
  logic [3:0]  addr = 4'h0, base = 4'h0;
  logic [1:0]  st = 2'h0, k = 2'h0;
  logic [1:0]  pv [3] = '{2'h0, 2'h0, 2'h0};
  logic [3:0]  pa [3];
  logic [7:0]  pm [3];
  logic [71:0] mem [16];
  logic [71:0] cd, din, dout, doe_n;
  logic        slept, cen = 0;
  int          seed = 32'h078cce29, num_errors = 0, n_tests = 0, cycles = 0;
  initial forever #20 clk = ~clk;
  pnsp_port #(.ADDR_W(4)) pnsp_port_inst (
    .CORE_CLK(clk), .RST(rst), .CLOCK_GATE_N_HOLD(gate), .SELECT_N(sn),
    .SECONDARY_SELECTS(s2), .SECONDARY_SELECTS_N(s2n),
    .ADVANCE_OR_LOAD(advance_or_load), .WRITE_SELECT_N(wen), .BYTE_LANE_WRITE_N(bw),
    .ADDRESS(addr), .BURST_ORDER(ord), .OUTPUT_ENABLE_N(oen),
    .SLEEP_REQUEST(slp), .DATA_LANES_IN(din), .DATA_LANES_OUT(dout),
    .DATA_LANES_OE_N(doe_n), .SLEEPING(slept));
  pnsp_ctrl_model pnsp_ctrl_model_inst (.clk(clk), .gate(gate), .sel_n(sn),
    .sel2(s2), .sel2_n(s2n), .advance_or_load(advance_or_load), .wr_n(wen), .din(din));
  task automatic chk(input string nm, input logic [71:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ****************************************
  // Reference model, one step per enabled edge
  // ****************************************
  always @(posedge clk) begin
    logic [1:0] lo;
    cen = !rst && !gate;
    if (cen) begin
      if (!advance_or_load) begin
        if (!sn && s2 && !s2n) begin
          st = wen ? 2'h1 : 2'h2;
          base = addr;
          k = 2'h0;
        end else st = 2'h0;
      end else if (st != 2'h0) k = k + 2'h1;
      lo = ord ? base[1:0] ^ k : base[1:0] + k;
      if (pv[1] == 2'h1) cd = mem[pa[1]];
      if (pv[1] == 2'h2)
        for (int g = 0; g < 8; g++)
          if (!pm[1][g]) mem[pa[1]][g*9+:9] = din[g*9+:9];
      pv[2] = pv[1];
      pa[2] = pa[1];
      pm[2] = pm[1];
      pv[1] = pv[0];
      pa[1] = pa[0];
      pm[1] = pm[0];
      pv[0] = (st == 2'h2 && bw == 8'hff) ? 2'h0 : st;
      pa[0] = {base[3:2], lo};
      pm[0] = bw;
    end
  end
  always @(negedge clk) begin
    if (cen && pv[2] == 2'h1 && !oen && !slp) begin
      chk("oe_n", doe_n, '0);
      chk("rdata", dout, cd);
    end else if (cen) chk("oe_n", doe_n, '1);
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      final_report;
    end
  end
  // ****************************************
  // Command sequences
  // ****************************************
  task automatic desel(input int n);
    repeat (n) begin
      @(posedge clk);
      gate <= 0;
      sn <= 1;
      advance_or_load <= 0;
    end
  endtask
  task automatic rnd(input int n);
    logic [31:0] r;
    repeat (n) begin
      @(posedge clk);
      r = $random(seed);
      gate <= r[2:0] == 3'h0;
      advance_or_load <= r[3] & r[4];
      sn <= r[5] & r[6] & r[7];
      s2 <= !(r[8] & r[9] & r[10]);
      s2n <= r[11] & r[12] & r[13];
      wen <= r[14] | (!oen & !slp);
      bw <= (r[15] & r[28]) ? 8'hff : r[23:16];
      addr <= r[27:24];
    end
  endtask
  task automatic phase(input int id, input logic o, e, z, input int n);
    desel(4);
    ord <= o;
    oen <= e;
    slp <= z;
    desel(8);
    chk("sleeping", {71'h0, slept}, {71'h0, z});
    rnd(n);
    $display("test %0d done", id);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    desel(6);
    for (int g = 0; g < 16; g++) begin
      @(posedge clk);
      sn <= 0;
      s2 <= 1;
      s2n <= 0;
      wen <= 0;
      bw <= 8'h00;
      advance_or_load <= g[1:0] != 2'h0;
      addr <= 4'(g);
    end
    phase(1, 0, 1, 0, 300);
    phase(2, 1, 0, 0, 300);
    phase(3, 1, 1, 0, 200);
    phase(4, 0, 0, 0, 200);
    phase(5, 1, 0, 1, 100);
    desel(4);
    final_report;
  end
endmodule // pnsp_port_tb_top
